// ### cbb_branch_unit.sv
// Decode and timing of the bit and branch instruction groups, plus the pointer,
// stack, accumulator and auxiliary registers reached over APB.
// Assumes operand values and the prefetch alignment arrive with each issue.
//
// Notes on behaviour
// - Carry AND/OR with bit: two cycles
// - Bit to carry moves: two cycles
// - Carry jumps: 2, taken 4 to 6
// - Bit jumps: 3, taken 5-7, clear variant
// - Relative offset signed, from next instruction
// - Short jump takes 4 to 6 cycles
// - Page target keeps upper five address bits
// - Far target is full 16 bits
// - Indexed jump targets accumulator plus pointer
// - Zero jumps: 2, taken 4 to 6
// - Compare direct/indirect: 4, taken 6-8
// - Compare register 3/5-7, accumulator 3/6-8
// - Decrement jumps: register 2/4-6, direct 3/5-7
// - No-operation and spare opcode: one cycle
// - Direct address upper half selects SFR
// - Bank registers, pointer only register 0/1
// - Two pointer bytes form wide pointer
// - Stack pointer increments before each push
// - Reset: stack seven, others zero
// - Accumulator, auxiliary bit-addressable, accumulator loads
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
module cbb_branch_unit (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic [31:0] o_prdata,
  input wire logic i_issue,
  input wire cbb_pkg::cbb_ins_t i_ins,
  input wire logic i_acc_we,
  input wire logic [7:0] i_acc_data,
  output logic o_ready,
  output logic o_done,
  output cbb_pkg::cbb_res_t o_res,
  output logic [7:0] o_acc,
  output logic [7:0] o_aux,
  output logic [7:0] o_stack_top_ptr,
  output logic [15:0] o_wide_data_pointer
);
  logic [7:0] stack_ff;
  logic [7:0] dpl_ff;
  logic [7:0] dph_ff;
  logic [7:0] acc_ff;
  logic [7:0] aux_ff;
  logic ready_ff;
  logic done_ff;
  logic [3:0] cnt_ff;
  cbb_pkg::cbb_res_t res_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  cbb_pkg::cbb_res_t nxt_res;
  logic [3:0] nxt_cyc;
  logic fire;
  logic apb_wr;
  logic [7:0] src_byte;
  logic src_bit;
  logic int_acc_bit;
  logic int_aux_bit;
  logic [7:0] cmp_a;
  logic [7:0] cmp_b;
  logic [7:0] rd_val;
  logic rd_hit;

  // Byte holding a bit address: low half maps into the RAM bit area
  function automatic logic [7:0] bit_byte(input logic [7:0] a);
    bit_byte = a[7] ? {a[7:3], 3'h0} : (cbb_pkg::BIT_RAM_BASE + {4'h0, a[6:3]});
  endfunction

  function automatic logic [15:0] rel_target(input logic [15:0] pc, input logic [7:0] r);
    rel_target = pc + {{8{r[7]}}, r};
  endfunction

  // Alignment beyond the documented spread is clipped
  function automatic logic [3:0] taken_cyc(input logic [3:0] base, input logic [1:0] al);
    taken_cyc = base + ((al > cbb_pkg::ALIGN_MAX) ? {2'h0, cbb_pkg::ALIGN_MAX} : {2'h0, al});
  endfunction

  assign fire = i_issue && ready_ff;
  assign apb_wr = i_psel && i_penable && i_pwrite && pready_ff;

  always_comb begin
    logic [7:0] ba;
    logic tk;
    logic [3:0] cnt_nt;
    logic [3:0] cnt_tk;
    logic cond_br;
    ba = bit_byte(i_ins.byte1);
    tk = 1'b0;
    cnt_nt = cbb_pkg::CYC_ONE;
    cnt_tk = cbb_pkg::CYC_ONE;
    cond_br = 1'b0;
    int_acc_bit = (ba == cbb_pkg::IDX_ARITH_MAIN_OPERAND);
    int_aux_bit = (ba == cbb_pkg::IDX_MULTIPLY_AUX_OPERAND);
    src_byte = int_acc_bit ? acc_ff : aux_ff;
    // Accumulator and auxiliary bits are served here, others come in
    src_bit = (int_acc_bit || int_aux_bit) ? src_byte[i_ins.byte1[2:0]] : i_ins.bitv;
    cmp_a = acc_ff;
    cmp_b = i_ins.byte1;
    nxt_res = '0;
    nxt_res.target = i_ins.next_pc;
    nxt_res.carry = i_ins.carry;
    nxt_res.bit_addr = i_ins.byte1;
    nxt_res.opnd_addr = i_ins.byte1;
    nxt_res.opnd_sfr = i_ins.byte1 >= cbb_pkg::SFR_SPLIT;
    case (i_ins.opcode)
      cbb_pkg::OP_NO_OPERATION, cbb_pkg::OP_SPARE_NOP: begin
        cnt_nt = cbb_pkg::CYC_ONE;
      end
      cbb_pkg::OP_AND_C_BIT, cbb_pkg::OP_AND_C_NBIT, cbb_pkg::OP_OR_C_BIT,
      cbb_pkg::OP_OR_C_NBIT: begin
        cnt_nt = cbb_pkg::CYC_BIT_OP;
        nxt_res.carry_we = 1'b1;
        if (i_ins.opcode == cbb_pkg::OP_AND_C_BIT) begin
          nxt_res.carry = i_ins.carry & src_bit;
        end else if (i_ins.opcode == cbb_pkg::OP_AND_C_NBIT) begin
          nxt_res.carry = i_ins.carry & ~src_bit;
        end else if (i_ins.opcode == cbb_pkg::OP_OR_C_BIT) begin
          nxt_res.carry = i_ins.carry | src_bit;
        end else begin
          nxt_res.carry = i_ins.carry | ~src_bit;
        end
      end
      cbb_pkg::OP_MOV_C_BIT: begin
        cnt_nt = cbb_pkg::CYC_BIT_OP;
        nxt_res.carry_we = 1'b1;
        nxt_res.carry = src_bit;
      end
      cbb_pkg::OP_MOV_BIT_C, cbb_pkg::OP_FORCE_ONE_BIT, cbb_pkg::OP_INVERT_BIT: begin
        cnt_nt = cbb_pkg::CYC_BIT_OP;
        nxt_res.bit_we = 1'b1;
        nxt_res.bit_val = (i_ins.opcode == cbb_pkg::OP_MOV_BIT_C) ? i_ins.carry :
                          (i_ins.opcode == cbb_pkg::OP_INVERT_BIT) ? ~src_bit : 1'b1;
      end
      cbb_pkg::OP_FORCE_ONE_C, cbb_pkg::OP_INVERT_C, cbb_pkg::OP_CLEAR_C: begin
        nxt_res.carry_we = 1'b1;
        nxt_res.carry = (i_ins.opcode == cbb_pkg::OP_FORCE_ONE_C) ? 1'b1 :
                        (i_ins.opcode == cbb_pkg::OP_INVERT_C) ? ~i_ins.carry : 1'b0;
      end
      cbb_pkg::OP_JUMP_ON_CARRY, cbb_pkg::OP_JUMP_ON_NO_CARRY: begin
        cond_br = 1'b1;
        cnt_nt = cbb_pkg::CYC_SHORT_NT;
        cnt_tk = cbb_pkg::CYC_SHORT_TK;
        tk = i_ins.carry ^ (i_ins.opcode == cbb_pkg::OP_JUMP_ON_NO_CARRY);
        nxt_res.target = rel_target(i_ins.next_pc, i_ins.byte1);
      end
      cbb_pkg::OP_JUMP_ON_BIT_SET, cbb_pkg::OP_JUMP_ON_BIT_CLEAR,
      cbb_pkg::OP_JUMP_TEST_CLEAR_BIT: begin
        cond_br = 1'b1;
        cnt_nt = cbb_pkg::CYC_LONG_NT;
        cnt_tk = cbb_pkg::CYC_LONG_TK;
        tk = src_bit ^ (i_ins.opcode == cbb_pkg::OP_JUMP_ON_BIT_CLEAR);
        nxt_res.target = rel_target(i_ins.next_pc, i_ins.byte2);
        // Clear happens only on the jump
        nxt_res.bit_we = tk && (i_ins.opcode == cbb_pkg::OP_JUMP_TEST_CLEAR_BIT);
        nxt_res.bit_val = 1'b0;
      end
      cbb_pkg::OP_FAR_JUMP, cbb_pkg::OP_FAR_CALL: begin
        tk = 1'b1;
        cnt_tk = cbb_pkg::CYC_LONG_TK;
        nxt_res.target = {i_ins.byte1, i_ins.byte2};
        nxt_res.push_we = (i_ins.opcode == cbb_pkg::OP_FAR_CALL);
      end
      cbb_pkg::OP_SHORT_REL_JUMP: begin
        tk = 1'b1;
        cnt_tk = cbb_pkg::CYC_SHORT_TK;
        nxt_res.target = rel_target(i_ins.next_pc, i_ins.byte1);
      end
      cbb_pkg::OP_INDEXED_JUMP: begin
        tk = 1'b1;
        cnt_tk = cbb_pkg::CYC_INDEXED;
        nxt_res.target = {8'h00, acc_ff} + {dph_ff, dpl_ff};
      end
      cbb_pkg::OP_JUMP_IF_ZERO, cbb_pkg::OP_JUMP_IF_NONZERO: begin
        cond_br = 1'b1;
        cnt_nt = cbb_pkg::CYC_SHORT_NT;
        cnt_tk = cbb_pkg::CYC_SHORT_TK;
        tk = (acc_ff == 8'h00) ^ (i_ins.opcode == cbb_pkg::OP_JUMP_IF_NONZERO);
        nxt_res.target = rel_target(i_ins.next_pc, i_ins.byte1);
      end
      cbb_pkg::OP_DEC_DIR: begin
        cond_br = 1'b1;
        cnt_nt = cbb_pkg::CYC_LONG_NT;
        cnt_tk = cbb_pkg::CYC_LONG_TK;
        nxt_res.byte_we = 1'b1;
        nxt_res.byte_data = i_ins.opnd - 8'h01;
        tk = (nxt_res.byte_data != 8'h00);
        nxt_res.target = rel_target(i_ins.next_pc, i_ins.byte2);
      end
      default: begin
        if (i_ins.opcode[4:0] == cbb_pkg::OP_PAGE_JUMP_LOW ||
            i_ins.opcode[4:0] == cbb_pkg::OP_PAGE_CALL_LOW) begin
          tk = 1'b1;
          cnt_tk = cbb_pkg::CYC_SHORT_TK;
          nxt_res.target = {i_ins.next_pc[15:11], i_ins.opcode[7:5], i_ins.byte1};
          nxt_res.push_we = i_ins.opcode[4];
        end else if (i_ins.opcode[7:4] == cbb_pkg::OP_CMP_ACC_IMM[7:4] &&
                     i_ins.opcode[3:2] != 2'b00 || i_ins.opcode == cbb_pkg::OP_CMP_ACC_IMM ||
                     i_ins.opcode == cbb_pkg::OP_CMP_ACC_DIR) begin
          cond_br = 1'b1;
          nxt_res.target = rel_target(i_ins.next_pc, i_ins.byte2);
          nxt_res.carry_we = 1'b1;
          if (i_ins.opcode == cbb_pkg::OP_CMP_ACC_DIR) begin
            cmp_b = i_ins.opnd;
            cnt_nt = cbb_pkg::CYC_CMP_NT;
            cnt_tk = cbb_pkg::CYC_CMP_TK;
          end else if (i_ins.opcode == cbb_pkg::OP_CMP_ACC_IMM) begin
            cnt_nt = cbb_pkg::CYC_LONG_NT;
            cnt_tk = cbb_pkg::CYC_CMP_TK;
          end else if (i_ins.opcode[7:1] == cbb_pkg::OP_CMP_IND_HI) begin
            cmp_a = i_ins.opnd;
            cnt_nt = cbb_pkg::CYC_CMP_NT;
            cnt_tk = cbb_pkg::CYC_CMP_TK;
            // Only register 0 or 1 of the bank can point
            nxt_res.opnd_addr = {3'h0, i_ins.bank, 2'h0, i_ins.opcode[0]};
            nxt_res.opnd_sfr = 1'b0;
          end else begin
            cmp_a = i_ins.opnd;
            cnt_nt = cbb_pkg::CYC_LONG_NT;
            cnt_tk = cbb_pkg::CYC_LONG_TK;
            nxt_res.opnd_addr = {3'h0, i_ins.bank, i_ins.opcode[2:0]};
            nxt_res.opnd_sfr = 1'b0;
          end
          tk = (cmp_a != cmp_b);
          nxt_res.carry = (cmp_a < cmp_b);
        end else if (i_ins.opcode[7:3] == cbb_pkg::OP_DEC_REG_HI) begin
          cond_br = 1'b1;
          cnt_nt = cbb_pkg::CYC_SHORT_NT;
          cnt_tk = cbb_pkg::CYC_SHORT_TK;
          nxt_res.opnd_addr = {3'h0, i_ins.bank, i_ins.opcode[2:0]};
          nxt_res.opnd_sfr = 1'b0;
          nxt_res.byte_we = 1'b1;
          nxt_res.byte_data = i_ins.opnd - 8'h01;
          tk = (nxt_res.byte_data != 8'h00);
          nxt_res.target = rel_target(i_ins.next_pc, i_ins.byte1);
        end else begin
          nxt_res.unknown = 1'b1;
        end
      end
    endcase
    // Return address pushes go to stack+1 then stack+2
    nxt_res.push_addr_lo = stack_ff + 8'h01;
    nxt_res.push_addr_hi = stack_ff + 8'h02;
    nxt_res.taken = tk;
    if (!tk) begin
      nxt_res.target = i_ins.next_pc;
    end
    // Taken cost depends on where the target sits in the prefetch buffer
    nxt_cyc = tk ? taken_cyc(cnt_tk, i_ins.align) : cnt_nt;
    if (!cond_br && !tk) begin
      nxt_cyc = cnt_nt;
    end
  end

  // Issue sequencer: ready returns in the cycle that done shows
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ready_ff <= 1'b1;
      done_ff <= 1'b0;
      cnt_ff <= 4'h0;
      res_ff <= '0;
    end else if (i_ce) begin
      if (fire) begin
        res_ff <= nxt_res;
        cnt_ff <= nxt_cyc - 4'h1;
        ready_ff <= (nxt_cyc == cbb_pkg::CYC_ONE);
        done_ff <= (nxt_cyc == cbb_pkg::CYC_ONE);
      end else if (cnt_ff != 4'h0) begin
        cnt_ff <= cnt_ff - 4'h1;
        ready_ff <= (cnt_ff == 4'h1);
        done_ff <= (cnt_ff == 4'h1);
      end else begin
        done_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      stack_ff <= cbb_pkg::RST_STACK_TOP_PTR;
    end else if (i_ce) begin
      if (apb_wr && i_paddr[9:2] == cbb_pkg::IDX_STACK_TOP_PTR) begin
        stack_ff <= i_pwdata[7:0];
      end else if (fire && nxt_res.push_we) begin
        stack_ff <= stack_ff + 8'h02;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      dpl_ff <= cbb_pkg::RST_ZERO;
      dph_ff <= cbb_pkg::RST_ZERO;
    end else if (i_ce && apb_wr) begin
      if (i_paddr[9:2] == cbb_pkg::IDX_POINTER_LOW_BYTE) begin
        dpl_ff <= i_pwdata[7:0];
      end
      if (i_paddr[9:2] == cbb_pkg::IDX_POINTER_HIGH_BYTE) begin
        dph_ff <= i_pwdata[7:0];
      end
    end
  end

  // Software write wins over the core load in the same cycle
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      acc_ff <= cbb_pkg::RST_ZERO;
      aux_ff <= cbb_pkg::RST_ZERO;
    end else if (i_ce) begin
      if (apb_wr && i_paddr[9:2] == cbb_pkg::IDX_ARITH_MAIN_OPERAND) begin
        acc_ff <= i_pwdata[7:0];
      end else if (i_acc_we) begin
        acc_ff <= i_acc_data;
      end else if (fire && nxt_res.bit_we && int_acc_bit) begin
        acc_ff[i_ins.byte1[2:0]] <= nxt_res.bit_val;
      end
      if (apb_wr && i_paddr[9:2] == cbb_pkg::IDX_MULTIPLY_AUX_OPERAND) begin
        aux_ff <= i_pwdata[7:0];
      end else if (fire && nxt_res.bit_we && int_aux_bit) begin
        aux_ff[i_ins.byte1[2:0]] <= nxt_res.bit_val;
      end
    end
  end

  always_comb begin
    rd_hit = 1'b1;
    case (i_paddr[9:2])
      cbb_pkg::IDX_STATUS: rd_val = {6'h00, res_ff.taken, ~ready_ff};
      cbb_pkg::IDX_STACK_TOP_PTR: rd_val = stack_ff;
      cbb_pkg::IDX_POINTER_LOW_BYTE: rd_val = dpl_ff;
      cbb_pkg::IDX_POINTER_HIGH_BYTE: rd_val = dph_ff;
      cbb_pkg::IDX_ARITH_MAIN_OPERAND: rd_val = acc_ff;
      cbb_pkg::IDX_MULTIPLY_AUX_OPERAND: rd_val = aux_ff;
      default: begin
        rd_val = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
    if (i_paddr[11:10] != 2'b00 || i_paddr[1:0] != 2'b00) begin
      rd_hit = 1'b0;
    end
  end

  // Zero-wait APB: answer is prepared during the setup cycle
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else if (i_ce) begin
      pready_ff <= i_psel && !i_penable;
      pslverr_ff <= i_psel && !i_penable && !rd_hit;
      prdata_ff <= (i_psel && !i_penable && !i_pwrite) ? {24'h00_0000, rd_val} : 32'h0000_0000;
    end
  end

  assign o_pready = pready_ff;
  assign o_pslverr = pslverr_ff;
  assign o_prdata = prdata_ff;
  assign o_ready = ready_ff;
  assign o_done = done_ff;
  assign o_res = res_ff;
  assign o_acc = acc_ff;
  assign o_aux = aux_ff;
  assign o_stack_top_ptr = stack_ff;
  assign o_wide_data_pointer = {dph_ff, dpl_ff};

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst || !i_ce);

  property p_rst_vals;
    @(posedge i_clk) disable iff (1'b0)
      i_rst |=> stack_ff == 8'h07 && acc_ff == 8'h00 && aux_ff == 8'h00 &&
      {dph_ff, dpl_ff} == 16'h0000;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("reset values wrong");
  property p_nop_one;
    fire && (i_ins.opcode == 8'hA5 || i_ins.opcode == 8'h00) |=> o_done && o_ready && !o_res.taken;
  endproperty
  a_nop_one: assert property (p_nop_one) else $error("no-operation not one cycle");
  property p_carry_nt;
    fire && i_ins.opcode == 8'h40 && !i_ins.carry |=> !o_done ##1 o_done;
  endproperty
  a_carry_nt: assert property (p_carry_nt) else $error("carry jump not-taken timing");
  property p_short_rel_jump_time;
    fire && i_ins.opcode == 8'h80 |=> !o_done[*3] ##[0:2] o_done;
  endproperty
  a_short_rel_jump_time: assert property (p_short_rel_jump_time) else $error("short jump timing");
  property p_short_rel_jump_tgt;
    fire && i_ins.opcode == 8'h80 |=>
      o_res.target == $past(i_ins.next_pc) + {{8{$past(i_ins.byte1[7])}}, $past(i_ins.byte1)};
  endproperty
  a_short_rel_jump_tgt: assert property (p_short_rel_jump_tgt) else $error("relative target wrong");
  property p_page_tgt;
    fire && i_ins.opcode[3:0] == 4'h1 |=>
      o_res.taken && o_res.target[15:11] == $past(i_ins.next_pc[15:11]);
  endproperty
  a_page_tgt: assert property (p_page_tgt) else $error("page target left page");
  property p_far_tgt;
    fire && (i_ins.opcode == 8'h02 || i_ins.opcode == 8'h12) |=>
      o_res.target == {$past(i_ins.byte1), $past(i_ins.byte2)};
  endproperty
  a_far_tgt: assert property (p_far_tgt) else $error("far target wrong");
  property p_idx_tgt;
    fire && i_ins.opcode == 8'h73 |=>
      o_res.target == {8'h00, $past(acc_ff)} + $past(o_wide_data_pointer);
  endproperty
  a_idx_tgt: assert property (p_idx_tgt) else $error("indexed target wrong");
  property p_push_pre;
    fire && i_ins.opcode == 8'h12 |=>
      stack_ff == $past(stack_ff) + 8'h02 && o_res.push_addr_lo == $past(stack_ff) + 8'h01;
  endproperty
  a_push_pre: assert property (p_push_pre) else $error("stack push order wrong");
  property p_jbc_clr;
    fire && i_ins.opcode == 8'h10 && i_ins.byte1 < 8'h80 && i_ins.bitv |=>
      o_res.bit_we && !o_res.bit_val && o_res.taken;
  endproperty
  a_jbc_clr: assert property (p_jbc_clr) else $error("tested bit not cleared");
  property p_cmp_nt;
    fire && i_ins.opcode == 8'hB5 && i_ins.opnd == acc_ff |=> !o_done[*3] ##1 o_done;
  endproperty
  a_cmp_nt: assert property (p_cmp_nt) else $error("compare not-taken timing");
  c_taken_jc: cover property (fire && i_ins.opcode == 8'h40 && i_ins.carry ##[4:6] o_done);
  c_far_call: cover property (fire && i_ins.opcode == 8'h12);
  c_apb_rd: cover property (i_psel && i_penable && !i_pwrite && o_pready);
endmodule

// ### cbb_pkg.sv
// Constants, opcodes and carrier types of the branch and bit-operation unit.
// Assumes a single clock domain; all users refer to names as cbb_pkg::name.
package cbb_pkg;
  // Register indexes; the APB byte address is four times the index
  localparam logic [7:0] IDX_STATUS = 8'h00;
  localparam logic [7:0] IDX_STACK_TOP_PTR = 8'h81;
  localparam logic [7:0] IDX_POINTER_LOW_BYTE = 8'h82;
  localparam logic [7:0] IDX_POINTER_HIGH_BYTE = 8'h83;
  localparam logic [7:0] IDX_ARITH_MAIN_OPERAND = 8'hE0;
  localparam logic [7:0] IDX_MULTIPLY_AUX_OPERAND = 8'hF0;
  localparam logic [7:0] RST_STACK_TOP_PTR = 8'h07;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] SFR_SPLIT = 8'h80;
  localparam logic [7:0] BIT_RAM_BASE = 8'h20;
  // Opcodes
  localparam logic [7:0] OP_NO_OPERATION = 8'h00;
  localparam logic [7:0] OP_SPARE_NOP = 8'hA5;
  localparam logic [7:0] OP_AND_C_BIT = 8'h82;
  localparam logic [7:0] OP_AND_C_NBIT = 8'hB0;
  localparam logic [7:0] OP_OR_C_BIT = 8'h72;
  localparam logic [7:0] OP_OR_C_NBIT = 8'hA0;
  localparam logic [7:0] OP_MOV_C_BIT = 8'hA2;
  localparam logic [7:0] OP_MOV_BIT_C = 8'h92;
  localparam logic [7:0] OP_FORCE_ONE_BIT = 8'hD2;
  localparam logic [7:0] OP_INVERT_BIT = 8'hB2;
  localparam logic [7:0] OP_FORCE_ONE_C = 8'hD3;
  localparam logic [7:0] OP_INVERT_C = 8'hB3;
  localparam logic [7:0] OP_CLEAR_C = 8'hC3;
  localparam logic [7:0] OP_JUMP_ON_CARRY = 8'h40;
  localparam logic [7:0] OP_JUMP_ON_NO_CARRY = 8'h50;
  localparam logic [7:0] OP_JUMP_ON_BIT_SET = 8'h20;
  localparam logic [7:0] OP_JUMP_ON_BIT_CLEAR = 8'h30;
  localparam logic [7:0] OP_JUMP_TEST_CLEAR_BIT = 8'h10;
  localparam logic [4:0] OP_PAGE_JUMP_LOW = 5'h01;
  localparam logic [4:0] OP_PAGE_CALL_LOW = 5'h11;
  localparam logic [7:0] OP_FAR_JUMP = 8'h02;
  localparam logic [7:0] OP_FAR_CALL = 8'h12;
  localparam logic [7:0] OP_SHORT_REL_JUMP = 8'h80;
  localparam logic [7:0] OP_INDEXED_JUMP = 8'h73;
  localparam logic [7:0] OP_JUMP_IF_ZERO = 8'h60;
  localparam logic [7:0] OP_JUMP_IF_NONZERO = 8'h70;
  localparam logic [7:0] OP_CMP_ACC_IMM = 8'hB4;
  localparam logic [7:0] OP_CMP_ACC_DIR = 8'hB5;
  localparam logic [6:0] OP_CMP_IND_HI = 7'h5B;
  localparam logic [4:0] OP_CMP_REG_HI = 5'h17;
  localparam logic [7:0] OP_DEC_DIR = 8'hD5;
  localparam logic [4:0] OP_DEC_REG_HI = 5'h1B;
  // Cycle counts: not taken, and least when taken
  localparam logic [3:0] CYC_ONE = 4'h1;
  localparam logic [3:0] CYC_BIT_OP = 4'h2;
  localparam logic [3:0] CYC_SHORT_NT = 4'h2;
  localparam logic [3:0] CYC_SHORT_TK = 4'h4;
  localparam logic [3:0] CYC_LONG_NT = 4'h3;
  localparam logic [3:0] CYC_LONG_TK = 4'h5;
  localparam logic [3:0] CYC_CMP_NT = 4'h4;
  localparam logic [3:0] CYC_CMP_TK = 4'h6;
  localparam logic [3:0] CYC_INDEXED = 4'h3;
  localparam logic [1:0] ALIGN_MAX = 2'h2;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] byte1;
    logic [7:0] byte2;
    logic [15:0] next_pc;
    logic carry;
    logic [1:0] bank;
    logic [7:0] opnd;
    logic bitv;
    logic [1:0] align;
  } cbb_ins_t;

  typedef struct packed {
    logic taken;
    logic [15:0] target;
    logic carry_we;
    logic carry;
    logic bit_we;
    logic bit_val;
    logic [7:0] bit_addr;
    logic [7:0] opnd_addr;
    logic opnd_sfr;
    logic byte_we;
    logic [7:0] byte_data;
    logic push_we;
    logic [7:0] push_addr_lo;
    logic [7:0] push_addr_hi;
    logic unknown;
  } cbb_res_t;
endpackage

// ### cbb_testbench.sv
// Self-checking bench for the branch and bit-operation unit.
// Assumes cbb_pkg is compiled first; the bench drives APB and the issue port itself.
`timescale 1ns/1ps
module testbench;
  logic i_clk, i_rst, i_ce, i_psel, i_penable, i_pwrite, i_issue, i_acc_we;
  logic o_pready, o_pslverr, o_ready, o_done, err;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, rd;
  logic [7:0] i_acc_data, o_acc, o_aux, o_stack_top_ptr;
  logic [15:0] o_wide_data_pointer;
  cbb_pkg::cbb_ins_t i_ins;
  cbb_pkg::cbb_res_t o_res;
  logic [11:0] zregs [4] = '{12'h208, 12'h20C, 12'h380, 12'h3C0};
  int fails, checks, n;
  cbb_branch_unit uut (.i_clk, .i_rst, .i_ce, .i_psel, .i_penable, .i_pwrite, .i_paddr,
    .i_pwdata, .o_pready, .o_pslverr, .o_prdata, .i_issue, .i_ins, .i_acc_we, .i_acc_data,
    .o_ready, .o_done, .o_res, .o_acc, .o_aux, .o_stack_top_ptr, .o_wide_data_pointer);
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_clk);
      k++;
    end while (o_pready !== 1'b1 && k < 16);
    if (o_pready !== 1'b1) fails++;
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [7:0] exp, input logic e);
    apb(1'b0, a, 32'h0);
    chk({err, rd}, {e, 24'h0, exp});
  endtask
  // Counts cycles from the accept edge to the done pulse
  task automatic iss(input logic [7:0] op, b1, b2, input logic [15:0] pc,
      input logic [7:0] od, input logic c, bv, input logic [1:0] al);
    @(posedge i_clk);
    i_ins <= '{op, b1, b2, pc, c, 2'h1, od, bv, al};
    i_issue <= 1'b1;
    @(posedge i_clk);
    i_issue <= 1'b0;
    n = 1;
    #1;
    while (o_done !== 1'b1 && n < 20) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    if (o_done !== 1'b1) fails++;
  endtask
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  // Whole run is about 120 cycles; this leaves a wide margin
  initial begin
    #200000;
    fails++;
    conclude();
  end
  initial begin
    fails = 0;
    checks = 0;
    i_rst = 1'b1;
    i_ce = 1'b1;
    i_psel = 1'b0;
    i_penable = 1'b0;
    i_pwrite = 1'b0;
    i_paddr = 12'h000;
    i_pwdata = 32'h0;
    i_issue = 1'b0;
    i_ins = '0;
    i_acc_we = 1'b0;
    i_acc_data = 8'h00;
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    rdchk(12'h204, 8'h07, 1'b0);
    foreach (zregs[i]) rdchk(zregs[i], 8'h00, 1'b0);
    rdchk(12'h010, 8'h00, 1'b1);
    apb(1'b1, 12'h208, 32'h34);
    apb(1'b1, 12'h20C, 32'h12);
    apb(1'b1, 12'h380, 32'h10);
    chk(o_wide_data_pointer, 16'h1234);
    iss(8'h73, 8'h00, 8'h00, 16'h0500, 8'h00, 1'b0, 1'b0, 2'h0);
    chk({n[3:0], o_res.taken, o_res.target}, {4'h3, 1'b1, 16'h1244});
    iss(8'h00, 8'h00, 8'h00, 16'h0001, 8'h00, 1'b0, 1'b0, 2'h0);
    chk({n[3:0], o_res.taken, o_ready}, {4'h1, 1'b0, 1'b1});
    iss(8'hA5, 8'h00, 8'h00, 16'h0002, 8'h00, 1'b1, 1'b1, 2'h2);
    chk({n[3:0], o_res.taken, o_res.carry_we}, {4'h1, 1'b0, 1'b0});
    iss(8'h82, 8'h21, 8'h00, 16'h0010, 8'h00, 1'b1, 1'b0, 2'h0);
    chk({n[3:0], o_res.carry_we, o_res.carry}, {4'h2, 1'b1, 1'b0});
    iss(8'hA0, 8'h21, 8'h00, 16'h0012, 8'h00, 1'b0, 1'b0, 2'h0);
    chk({n[3:0], o_res.carry_we, o_res.carry}, {4'h2, 1'b1, 1'b1});
    iss(8'h92, 8'h2A, 8'h00, 16'h0014, 8'h00, 1'b1, 1'b0, 2'h0);
    chk({n[3:0], o_res.bit_we, o_res.bit_val, o_res.bit_addr}, {4'h2, 2'b11, 8'h2A});
    iss(8'h40, 8'hFE, 8'h00, 16'h1002, 8'h00, 1'b0, 1'b0, 2'h2);
    chk({n[3:0], o_res.taken}, {4'h2, 1'b0});
    iss(8'h40, 8'hFE, 8'h00, 16'h1002, 8'h00, 1'b1, 1'b0, 2'h2);
    chk({n[3:0], o_res.taken, o_res.target}, {4'h6, 1'b1, 16'h1000});
    iss(8'h80, 8'h10, 8'h00, 16'h00F0, 8'h00, 1'b0, 1'b0, 2'h1);
    chk({n[3:0], o_res.taken, o_res.target}, {4'h5, 1'b1, 16'h0100});
    iss(8'h10, 8'h25, 8'h04, 16'h2003, 8'h00, 1'b0, 1'b1, 2'h0);
    chk({n[3:0], o_res.target, o_res.bit_we, o_res.bit_val}, {4'h5, 16'h2007, 2'b10});
    iss(8'hE1, 8'h55, 8'h00, 16'h37FE, 8'h00, 1'b0, 1'b0, 2'h0);
    chk({n[3:0], o_res.taken, o_res.target}, {4'h4, 1'b1, 16'h3755});
    iss(8'h12, 8'hAB, 8'hCD, 16'h0403, 8'h00, 1'b0, 1'b0, 2'h0);
    chk({n[3:0], o_res.target, o_res.push_we}, {4'h5, 16'hABCD, 1'b1});
    chk({o_res.push_addr_lo, o_res.push_addr_hi, o_stack_top_ptr}, 24'h08_0909);
    rdchk(12'h204, 8'h09, 1'b0);
    iss(8'h70, 8'h08, 8'h00, 16'h0600, 8'h00, 1'b0, 1'b0, 2'h0);
    chk({n[3:0], o_res.taken, o_res.target}, {4'h4, 1'b1, 16'h0608});
    rdchk(12'h000, 8'h02, 1'b0);
    iss(8'h60, 8'h08, 8'h00, 16'h0600, 8'h00, 1'b0, 1'b0, 2'h0);
    chk({n[3:0], o_res.taken}, {4'h2, 1'b0});
    iss(8'hB5, 8'h90, 8'h05, 16'h0700, 8'h10, 1'b0, 1'b0, 2'h0);
    chk({n[3:0], o_res.taken, o_res.opnd_sfr}, {4'h4, 2'b01});
    iss(8'hDB, 8'h05, 8'h00, 16'h0800, 8'h01, 1'b0, 1'b0, 2'h0);
    chk({n[3:0], o_res.taken, o_res.byte_data, o_res.opnd_addr},
      {4'h2, 1'b0, 16'h000B});
    iss(8'hD2, 8'hE7, 8'h00, 16'h0900, 8'h00, 1'b0, 1'b0, 2'h0);
    iss(8'hB2, 8'hF0, 8'h00, 16'h0902, 8'h00, 1'b0, 1'b0, 2'h0);
    chk({n[3:0], o_acc, o_aux}, {4'h2, 8'h90, 8'h01});
    @(posedge i_clk);
    i_acc_we <= 1'b1;
    i_acc_data <= 8'h5A;
    @(posedge i_clk);
    i_acc_we <= 1'b0;
    rdchk(12'h380, 8'h5A, 1'b0);
    conclude();
  end
endmodule
